//--- src/tsp_pkg.sv
// Package with the constants shared by the two-wire sensor register port.
`default_nettype none
package tsp_pkg;
  // Transaction framing in rising clock edges.
  localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h08;
  localparam logic [4:0] BIT_DATA_LAST = 5'h0f;
  localparam logic [4:0] BIT_IDLE = 5'h00;
  // Register addresses (seven bits).
  localparam logic [6:0] ADDR_CONFIG = 7'h40;
  localparam logic [6:0] ADDR_STATUS = 7'h41;
  // Configuration field positions and reset value.
  localparam int CFG_SOFT_RESET = 7;
  localparam int CFG_POWER_DOWN = 6;
  localparam int CFG_SHUTTER = 5;
  localparam int CFG_FORCED_AWAKE = 0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CFG_PD_MASK = 8'h40;
  localparam logic [7:0] CFG_SR_MASK = 8'h80;
  // Status layout; the identity code value is arbitrary.
  localparam logic [2:0] STATUS_ID = 3'h5;
  localparam logic [3:0] STATUS_RSVD = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Timing: system clock rate, transaction timeout and frame rate.
  localparam longint CLK_HZ = 125000000;
  localparam longint TRANSACTION_TIMEOUT_MS = 90;
  localparam longint TIMEOUT_CYCLES = TRANSACTION_TIMEOUT_MS * CLK_HZ / 1000;
  localparam longint FRAME_RATE_FPS = 1500;
  localparam longint FRAME_CYCLES = CLK_HZ / FRAME_RATE_FPS;
  localparam logic [1:0] SETTLE_FRAMES = 2'h3;
endpackage
`default_nettype wire

//--- src/tsp_link_if.sv
// Interface carrying the crossing signals between the serial-clock engine and the system core.
`default_nettype none
interface tsp_link_if;
  logic rd_req_tgl;
  logic wr_req_tgl;
  logic busy;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic port_rst;
  modport link (output rd_req_tgl, output wr_req_tgl, output busy, output addr, output wdata,
    input rdata, input port_rst);
  modport core (input rd_req_tgl, input wr_req_tgl, input busy, input addr, input wdata,
    output rdata, output port_rst);
endinterface
`default_nettype wire

//--- src/tsp_link.sv
// Serial-clock domain engine: shifts address and data, drives read data on the shared line.
`default_nettype none
module tsp_link (
  input wire logic sck,
  input wire logic rst,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  tsp_link_if.link lk
);
  logic [4:0] bit_cnt;
  logic [6:0] shreg;
  logic dir_write;
  logic [3:0] rd_idx;

  // Bit counter and shifter; a timeout from the core clears them so the next edge is a direction bit.
  always_ff @(posedge sck or posedge lk.port_rst or posedge rst) begin
    if (rst || lk.port_rst) begin
      bit_cnt <= tsp_pkg::BIT_IDLE;
      shreg <= 7'h00;
      dir_write <= 1'b0;
      lk.busy <= 1'b0;
    end else begin
      shreg <= {shreg[5:0], sdio_in};
      if (bit_cnt == tsp_pkg::BIT_IDLE) begin
        dir_write <= sdio_in;
      end
      if (bit_cnt == tsp_pkg::BIT_DATA_LAST) begin
        bit_cnt <= tsp_pkg::BIT_IDLE;
        lk.busy <= 1'b0;
      end else begin
        bit_cnt <= bit_cnt + 5'h01;
        lk.busy <= 1'b1;
      end
    end
  end

  // Address and data holding plus request toggles; only the power-on reset touches them.
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      lk.addr <= 7'h00;
      lk.wdata <= 8'h00;
      lk.rd_req_tgl <= 1'b0;
      lk.wr_req_tgl <= 1'b0;
    end else if (!lk.port_rst) begin
      if (bit_cnt == tsp_pkg::BIT_ADDR_LAST) begin
        lk.addr <= {shreg[5:0], sdio_in};
        if (!dir_write) begin
          lk.rd_req_tgl <= ~lk.rd_req_tgl;
        end
      end
      if (bit_cnt == tsp_pkg::BIT_DATA_LAST && dir_write) begin
        lk.wdata <= {shreg, sdio_in};
        lk.wr_req_tgl <= ~lk.wr_req_tgl;
      end
    end
  end

  assign rd_idx = 4'(tsp_pkg::BIT_DATA_LAST - bit_cnt);

  // Read data changes on falling edges; rdata has been stable since the host's address gap.
  always_ff @(negedge sck or posedge lk.port_rst or posedge rst) begin
    if (rst || lk.port_rst) begin
      sdio_oe <= 1'b0;
      sdio_out <= 1'b0;
    end else if (!dir_write && bit_cnt >= tsp_pkg::BIT_DATA_FIRST) begin
      sdio_oe <= 1'b1;
      sdio_out <= lk.rdata[rd_idx[2:0]];
    end else begin
      sdio_oe <= 1'b0;
      sdio_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- src/tsp_port.sv
// Top of the two-wire sensor register port: system-side registers, timeout and crossings.
// How it works
// - The host clocks every transfer; this port never starts one itself.
// - Write: direction bit 1, seven address bits, then one host data byte.
// - Driver changes the line on falling edges; receiver samples on rising edges.
// - Read: direction bit 0 with address, then the port drives eight data bits.
// - Port drives read data after the address and releases it at the falling edge after the last bit.
// - Last read bit stays on the line until the next falling edge.
// - Writing any data to an unused address keeps normal operation, line released.
// - Entering or leaving power-down by a write leaves the line released.
// - An unfinished transfer older than about 90 ms resets the port.
// - Writes to unassigned addresses change nothing; reads return zero.
// - Every rising edge counts as a bit, so host waits one timeout after power-up.
// - Writing the reset bit soft-resets; hardware clears that bit by itself. In power-down this port drops the reset bit of a write.
// - Other bits of the soft-reset write stay as written.
// - Digital logic is ready at once; analog settles after three frames.
// - Power-on reset initialises the whole port.
// - Configuration is at address 0x40; bit 6 selects power-down.
// - In power-down the timeout stops, so partial commands must not be sent.
`default_nettype none
module tsp_port #(
  parameter longint TIMEOUT_CYCLES = tsp_pkg::TIMEOUT_CYCLES,
  parameter longint FRAME_CYCLES = tsp_pkg::FRAME_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  input wire logic awake_in,
  output logic power_down_bit,
  output logic shutter_mode,
  output logic forced_awake,
  output logic analog_settled,
  output logic port_timeout
);
  localparam logic [23:0] TIMEOUT_LAST = 24'(TIMEOUT_CYCLES - 1);
  localparam logic [19:0] FRAME_LAST = 20'(FRAME_CYCLES - 1);

  tsp_link_if lk ();

  logic [7:0] config_reg;
  logic [7:0] rdata;
  logic [1:0] rd_sync;
  logic [1:0] wr_sync;
  logic [1:0] busy_sync;
  logic [1:0] awake_sync;
  logic rd_seen;
  logic wr_seen;
  logic rd_event;
  logic wr_event;
  logic [23:0] timer;
  logic timeout_rst;
  logic [19:0] frame_cnt;
  logic [1:0] settle_cnt;
  logic soft_rst_evt;
  logic cfg_write;

  // The serial-clock engine; only toggles, a busy level, the port reset and quasi-static words cross.
  tsp_link u_link (
    .sck(sck),
    .rst(rst),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .lk(lk.link)
  );

  assign lk.rdata = rdata;
  assign lk.port_rst = timeout_rst;

  // Two-flop synchronisers for the toggles and busy level from the link domain and the awake pin; addr and wdata are used unsynchronised.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_sync <= 2'h0;
      wr_sync <= 2'h0;
      busy_sync <= 2'h0;
      awake_sync <= 2'h0;
    end else begin
      rd_sync <= {rd_sync[0], lk.rd_req_tgl};
      wr_sync <= {wr_sync[0], lk.wr_req_tgl};
      busy_sync <= {busy_sync[0], lk.busy};
      awake_sync <= {awake_sync[0], awake_in};
    end
  end

  // Last seen toggle values turn each toggle into a one-cycle event.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_seen <= 1'b0;
      wr_seen <= 1'b0;
    end else begin
      rd_seen <= rd_sync[1];
      wr_seen <= wr_sync[1];
    end
  end

  // The link never starts anything on its own, so every event is a host transfer.
  assign rd_event = rd_sync[1] ^ rd_seen;
  assign wr_event = wr_sync[1] ^ wr_seen;
  assign cfg_write = wr_event && (lk.addr == tsp_pkg::ADDR_CONFIG);
  assign soft_rst_evt = config_reg[tsp_pkg::CFG_SOFT_RESET];

  // Configuration register. While powered down only the power-down bit takes a write,
  // and the reset bit clears itself one cycle after it is set.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      config_reg <= tsp_pkg::CONFIG_RESET;
    end else if (cfg_write) begin
      if (config_reg[tsp_pkg::CFG_POWER_DOWN]) begin
        config_reg <= (config_reg & ~tsp_pkg::CFG_PD_MASK) | (lk.wdata & tsp_pkg::CFG_PD_MASK);
      end else begin
        config_reg <= lk.wdata;
      end
    end else if (soft_rst_evt) begin
      config_reg <= config_reg & ~tsp_pkg::CFG_SR_MASK;
    end
  end

  // Read answers are prepared in the system domain and held until the next read request.
  // Reads of unassigned addresses load zero; writes to them leave everything untouched.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= tsp_pkg::UNMAPPED_READ;
    end else if (rd_event) begin
      unique case (lk.addr)
        tsp_pkg::ADDR_CONFIG: begin
          rdata <= config_reg;
        end
        tsp_pkg::ADDR_STATUS: begin
          rdata <= {tsp_pkg::STATUS_ID, tsp_pkg::STATUS_RSVD, awake_sync[1]};
        end
        default: begin
          rdata <= tsp_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  // Transaction timer. It runs only while a transfer is open and stops in power-down,
  // which is why a partial command during power-down can stall the port.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer <= 24'h000000;
    end else if (!busy_sync[1] || config_reg[tsp_pkg::CFG_POWER_DOWN]) begin
      timer <= 24'h000000;
    end else if (timer != TIMEOUT_LAST) begin
      timer <= timer + 24'h000001;
    end
  end

  // Port reset is held until the cleared busy level has crossed back, so it always ends.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timeout_rst <= 1'b0;
    end else if (busy_sync[1] && timer == TIMEOUT_LAST && !config_reg[tsp_pkg::CFG_POWER_DOWN]) begin
      timeout_rst <= 1'b1;
    end else if (!busy_sync[1]) begin
      timeout_rst <= 1'b0;
    end
  end

  // Frame counter provides the analog settling time base.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_cnt <= 20'h00000;
    end else if (soft_rst_evt || frame_cnt == FRAME_LAST) begin
      frame_cnt <= 20'h00000;
    end else begin
      frame_cnt <= frame_cnt + 20'h00001;
    end
  end

  // Analog results are flagged accurate only after three frames; digital state is usable at once.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_cnt <= 2'h0;
    end else if (soft_rst_evt) begin
      settle_cnt <= 2'h0;
    end else if (frame_cnt == FRAME_LAST && settle_cnt != tsp_pkg::SETTLE_FRAMES) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // Registered copies of configuration fields and status for the rest of the sensor.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_down_bit <= 1'b0;
      shutter_mode <= 1'b0;
      forced_awake <= 1'b0;
      analog_settled <= 1'b0;
      port_timeout <= 1'b0;
    end else begin
      power_down_bit <= config_reg[tsp_pkg::CFG_POWER_DOWN];
      shutter_mode <= config_reg[tsp_pkg::CFG_SHUTTER];
      forced_awake <= config_reg[tsp_pkg::CFG_FORCED_AWAKE];
      analog_settled <= (settle_cnt == tsp_pkg::SETTLE_FRAMES) && !soft_rst_evt;
      port_timeout <= timeout_rst;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tsp_port_checker.sv
// Assertion checker for the two-wire sensor register port, bound to its top.
`default_nettype none
module tsp_port_checker #(
  parameter longint FRAME_CYCLES = 40
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck,
  input wire logic sdio_in,
  input wire logic sdio_oe,
  input wire logic sdio_out,
  input wire logic power_down_bit,
  input wire logic analog_settled,
  input wire logic port_timeout
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] n;
  logic rd;
  logic [15:0] sc;
  // Shadow bit counter; a timeout clears it just as it clears the port's own counter.
  always_ff @(posedge sck or posedge rst or posedge port_timeout) begin
    if (rst || port_timeout) begin
      n <= 5'h00;
      rd <= 1'b0;
    end else begin
      n <= (n == 5'h0f) ? 5'h00 : n + 5'h01;
      if (n == 5'h00) rd <= !sdio_in;
    end
  end
  // Cycles spent unsettled, so the settling time can be bounded at both ends.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) sc <= 16'h0000;
    else sc <= analog_settled ? 16'h0000 : sc + 16'h0001;
  end
  read_window_a: assert property (@(posedge sck) disable iff (rst) (n < 5'h08 || !rd) |-> !sdio_oe)
    else $error("data line driven outside a read data phase");
  read_drive_a: assert property (@(posedge sck) disable iff (rst) (rd && n >= 5'h08) |-> sdio_oe)
    else $error("data line not driven in read data phase");
  hold_high_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sck && $past(sck) && !port_timeout) |-> ($stable(sdio_oe) && $stable(sdio_out)))
    else $error("data line changed while clock high");
  rise_low_a: assert property (@(posedge clk_sys) disable iff (rst) $rose(sdio_oe) |-> !sck)
    else $error("drive began away from a falling edge");
  pd_release_a: assert property (@(posedge clk_sys) disable iff (rst) $changed(power_down_bit) |-> !sdio_oe)
    else $error("line driven across power-down change");
  pd_no_timeout_a: assert property (@(posedge clk_sys) disable iff (rst) power_down_bit |-> !port_timeout)
    else $error("timeout fired in power-down");
  timeout_short_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(port_timeout) |-> ##[1:16] !port_timeout)
    else $error("port reset held too long");
  settle_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(analog_settled) |-> !analog_settled [*8])
    else $error("settled too soon after reset");
  settle_span_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(analog_settled) |-> (sc >= 2 * FRAME_CYCLES && sc <= 3 * FRAME_CYCLES + 8))
    else $error("settling time out of range");
  cover property (@(posedge sck) disable iff (rst) rd && n == 5'h0f);
  cover property (@(posedge clk_sys) disable iff (rst) $fell(analog_settled));
  cover property (@(posedge clk_sys) disable iff (rst) $rose(port_timeout));
endmodule
bind tsp_port tsp_port_checker #(.FRAME_CYCLES(FRAME_CYCLES)) chk (.clk_sys(clk_sys), .rst(rst), .sck(sck),
  .sdio_in(sdio_in), .sdio_oe(sdio_oe), .sdio_out(sdio_out), .power_down_bit(power_down_bit),
  .analog_settled(analog_settled), .port_timeout(port_timeout));
`default_nettype wire

//--- testbench/tsp_host_model.sv
// Host model: clocks the serial port and drives or releases the shared data line.
`default_nettype none
module tsp_host_model #(
  parameter int PREP_NS = 1000,
  parameter int GAP_NS = 300
) (
  output logic sck,
  output logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hd;
  logic hoe;
  logic last;
  // A released line has no pull, so it shows the inverse of its last level and never fakes data.
  always_comb sdio_in = sdio_oe ? sdio_out : (hoe ? hd : ~last);
  always @(posedge sck) last <= sdio_in;
  initial begin
    sck = 1'b1;
    hd = 1'b1;
    hoe = 1'b1;
    last = 1'b1;
  end
  // One bit: drive at the falling edge, sample at the rising edge.
  task automatic one_bit(input logic drv, input logic b, output logic s);
    sck = 1'b0;
    hoe = drv;
    hd = b;
    #80;
    sck = 1'b1;
    s = sdio_in;
    #80;
  endtask
  // A whole command; gaps are shortened but keep the required ordering.
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    logic s;
    f = {w, a, d};
    for (int i = 15; i >= 0; i--) begin
      one_bit(w || i > 7, f[i], s);
      if (i < 8) q[i] = s;
      if (i == 8 && !w) begin
        hoe = 1'b0;
        #(PREP_NS);
      end
    end
    #(GAP_NS);
  endtask
  // Partial command, as left by a glitch or an aborted host.
  task automatic stray(input int n);
    logic s;
    for (int i = 0; i < n; i++) one_bit(1'b1, 1'b0, s);
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the two-wire sensor register port.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic awake_in = 1'b0;
  logic sck, sdio_in, sdio_out, sdio_oe, power_down_bit, shutter_mode, forced_awake, analog_settled, port_timeout;
  logic to_seen = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  // Short timeout and frame keep the run brief; the timeout still outlasts a full read.
  tsp_port #(.TIMEOUT_CYCLES(2000), .FRAME_CYCLES(40)) uut (.clk_sys(clk_sys), .rst(rst), .sck(sck),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .awake_in(awake_in),
    .power_down_bit(power_down_bit), .shutter_mode(shutter_mode), .forced_awake(forced_awake),
    .analog_settled(analog_settled), .port_timeout(port_timeout));
  tsp_host_model host (.sck(sck), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe));
  always #4 clk_sys = ~clk_sys;
  always @(posedge port_timeout) to_seen = 1'b1;
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b1, a, d, x);
  endtask
  task automatic rdc(input string name, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] x;
    host.xfer(1'b0, a, 8'h00, x);
    chk(name, x, exp);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence; each step is chosen to expose a wrong edge, count or field.
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    chk("reset_pins", {4'h0, sdio_oe, power_down_bit, shutter_mode, forced_awake}, 8'h00);
    repeat (4) @(negedge clk_sys);
    host.stray(1);
    #20000;
    chk("power_up_timeout", {7'h0, to_seen}, 8'h01);
    awake_in = 1'b1;
    rdc("status_awake", tsp_pkg::ADDR_STATUS, {tsp_pkg::STATUS_ID, 4'h0, 1'b1});
    #100;
    chk("d0_held", {6'h0, sdio_oe, sdio_out}, 8'h03);
    $display("test sync done");
    wr(7'h77, 8'hff);
    chk("unused_release", {7'h0, sdio_oe}, 8'h00);
    wr(tsp_pkg::ADDR_CONFIG, 8'h21);
    rdc("cfg_readback", tsp_pkg::ADDR_CONFIG, 8'h21);
    chk("cfg_pins", {5'h0, power_down_bit, shutter_mode, forced_awake}, 8'h03);
    rdc("unmapped_read", 7'h42, 8'h00);
    $display("test access done");
    wr(tsp_pkg::ADDR_CONFIG, 8'h61);
    chk("pd_on", {6'h0, sdio_oe, power_down_bit}, 8'h01);
    // A partial command in power-down must not time out; the remaining bits then close it.
    // The host keeps driving through that answer, which the model resolves in the port's favour.
    to_seen = 1'b0;
    host.stray(3);
    #20000;
    chk("pd_no_timeout", {7'h0, to_seen}, 8'h00);
    host.stray(13);
    #300;
    wr(tsp_pkg::ADDR_CONFIG, 8'h00);
    chk("pd_off", {4'h0, sdio_oe, power_down_bit, shutter_mode, forced_awake}, 8'h03);
    wr(tsp_pkg::ADDR_CONFIG, 8'ha1);
    chk("settle_low", {7'h0, analog_settled}, 8'h00);
    rdc("cfg_after_soft", tsp_pkg::ADDR_CONFIG, 8'h21);
    chk("settle_high", {7'h0, analog_settled}, 8'h01);
    $display("test config done");
    to_seen = 1'b0;
    host.stray(5);
    #20000;
    chk("mid_timeout", {7'h0, to_seen}, 8'h01);
    @(negedge clk_sys);
    awake_in = 1'b0;
    rdc("status_resync", tsp_pkg::ADDR_STATUS, {tsp_pkg::STATUS_ID, 4'h0, 1'b0});
    $display("test timeout done");
    stop_test;
  end
  // Watchdog: the sequence needs about 98 us.
  initial begin
    #500000;
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    stop_test;
  end
endmodule
`default_nettype wire
